// *** rtl/sas_serial_adc.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "sas_consts.svh"

module sas_serial_adc
  import sas_pkg::*;
#(
  parameter int RES_BITS = `SAS_RES_BITS,
  parameter int FIFO_DEPTH = `SAS_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Host pins
  input wire logic select_shutdown_n_i,
  input wire logic bit_clock_i,
  output logic serial_data_o,
  output logic serial_data_oe_o,
  // Analog front end
  input wire logic compare_high_i,
  output sas_pkg::sas_code_t trial_code_o,
  output logic sample_o,
  output logic analog_on_o,
  output logic digital_on_o,
  // Finished result
  output sas_pkg::sas_code_t result_o,
  output logic result_valid_o
);

  import sas_pkg::*;

  localparam int IW = $clog2(RES_BITS);

  // ****************************************************************
  // Pin capture
  // ****************************************************************
  logic [1:0] pin_lvl;
  logic [1:0] pin_fall;
  logic sel_n;
  logic sel_fall;
  logic bclk_fall;

  sas_pin_sync #(
    .WIDTH(2),
    .RST_VAL(`SAS_PIN_RST)
  ) u_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .pin_i({select_shutdown_n_i, bit_clock_i}),
    .level_o(pin_lvl),
    .rise_o(),
    .fall_o(pin_fall)
  );

  assign sel_n = pin_lvl[1];
  assign sel_fall = pin_fall[1];
  assign bclk_fall = pin_fall[0];

  // Step a bit index by one, either direction
  function automatic logic [IW-1:0] step_idx(input logic [IW-1:0] idx,
                                             input logic up);
    step_idx = up ? idx + IW'(1) : idx - IW'(1);
  endfunction

  // ****************************************************************
  // Transfer sequencer
  // ****************************************************************
  sas_state_t state_q;
  logic [1:0] fall_cnt_q;
  logic [IW-1:0] out_idx_q;
  sas_code_t result_q;
  logic conv_start;
  logic pop;
  logic buf_valid;
  logic buf_bit;

  // Second falling edge of the sample phase ends acquisition
  assign conv_start = !sel_n && bclk_fall && (state_q == SAS_SAMPLE)
    && (fall_cnt_q == 2'(`SAS_SAMPLE_FALLS - 1));
  // Decided bits leave the buffer on the fall that ends the null bit and during the MSB-first phase
  assign pop = !sel_n && bclk_fall && ((state_q == SAS_NULL)
    || ((state_q == SAS_MSB_FIRST) && (out_idx_q != '0)));

  // State, bit index and pin drive share one process so they never skew
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i || sel_n)
    begin
      state_q <= SAS_IDLE;
      fall_cnt_q <= '0;
      out_idx_q <= '0;
      serial_data_o <= 1'b0;
      serial_data_oe_o <= 1'b0;
    end
    else if (sel_fall && state_q == SAS_IDLE)
    begin
      state_q <= SAS_SAMPLE;
      fall_cnt_q <= '0;
    end
    else if (bclk_fall)
    begin
      case (state_q)
        SAS_SAMPLE:
        begin
          fall_cnt_q <= fall_cnt_q + 2'h1;
          if (conv_start)
          begin
            state_q <= SAS_NULL;
            serial_data_oe_o <= 1'b1;
            serial_data_o <= 1'b0;
          end
        end
        SAS_NULL:
        begin
          state_q <= SAS_MSB_FIRST;
          out_idx_q <= IW'(RES_BITS - 1);
          serial_data_o <= buf_valid & buf_bit;
        end
        SAS_MSB_FIRST:
        begin
          if (out_idx_q == '0)
          begin
            state_q <= SAS_LSB_FIRST;
            out_idx_q <= IW'(1);
            serial_data_o <= result_q[1];
          end
          else
          begin
            out_idx_q <= step_idx(out_idx_q, 1'b0);
            serial_data_o <= buf_valid & buf_bit;
          end
        end
        SAS_LSB_FIRST:
        begin
          if (out_idx_q == IW'(RES_BITS - 1))
          begin
            state_q <= SAS_DONE;
            serial_data_oe_o <= 1'b0;
            serial_data_o <= 1'b0;
          end
          else
          begin
            out_idx_q <= step_idx(out_idx_q, 1'b1);
            serial_data_o <= result_q[step_idx(out_idx_q, 1'b1)];
          end
        end
        SAS_DONE:
        begin
          state_q <= SAS_DONE;
        end
        default:
        begin
          state_q <= SAS_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Successive approximation search
  // ****************************************************************
  logic sar_busy_q;
  logic settle_q;
  logic [IW-1:0] sar_idx_q;
  logic push;
  logic push_ready;
  logic conv_done;

  // One cycle lets the trial code settle before the comparator is read
  assign push = sar_busy_q && settle_q && !sel_n;
  assign conv_done = push && push_ready && (sar_idx_q == '0);

  // Decisions run fast and stall while the buffer is full
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i || sel_n)
    begin
      sar_busy_q <= 1'b0;
      settle_q <= 1'b0;
      sar_idx_q <= '0;
      trial_code_o <= '0;
    end
    else if (conv_start)
    begin
      sar_busy_q <= 1'b1;
      settle_q <= 1'b0;
      sar_idx_q <= IW'(RES_BITS - 1);
      trial_code_o <= `SAS_MID_CODE;
    end
    else if (sar_busy_q && !settle_q)
    begin
      settle_q <= 1'b1;
    end
    else if (push && push_ready)
    begin
      trial_code_o[sar_idx_q] <= compare_high_i;
      settle_q <= 1'b0;
      if (sar_idx_q == '0)
      begin
        sar_busy_q <= 1'b0;
      end
      else
      begin
        trial_code_o[step_idx(sar_idx_q, 1'b0)] <= 1'b1;
        sar_idx_q <= step_idx(sar_idx_q, 1'b0);
      end
    end
  end

  // Result bits of this conversion only; cleared at each start
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i || conv_start)
    begin
      result_q <= '0;
    end
    else if (push && push_ready)
    begin
      result_q[sar_idx_q] <= compare_high_i;
    end
  end

  // Decided bits wait here for the falling edges that send them
  sas_fifo #(
    .WIDTH(1),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .flush_i(sel_n || conv_start),
    .in_valid_i(push),
    .in_data_i(compare_high_i),
    .in_ready_o(push_ready),
    .out_valid_o(buf_valid),
    .out_data_o(buf_bit),
    .out_ready_i(pop)
  );

  // ****************************************************************
  // Power and result outputs
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      sample_o <= 1'b0;
      analog_on_o <= 1'b0;
      digital_on_o <= 1'b0;
      result_o <= '0;
      result_valid_o <= 1'b0;
    end
    else
    begin
      digital_on_o <= !sel_n;
      sample_o <= !sel_n && (sample_o || (sel_fall && state_q == SAS_IDLE))
        && !conv_start;
      // Analog stays up from start until the last decision
      analog_on_o <= !sel_n && !conv_done
        && (analog_on_o || (sel_fall && state_q == SAS_IDLE));
      result_valid_o <= conv_done;
      if (conv_done)
      begin
        result_o <= {result_q[RES_BITS-1:1], compare_high_i};
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_start;
    sel_fall && !sel_n && state_q == SAS_IDLE;
  endsequence

  sequence s_null_edge;
    conv_start;
  endsequence

  a_start_sample: assert property (
    s_start |=> state_q == SAS_SAMPLE ##1 sample_o)
    else $error("select fall did not start sampling");
  // The first fall must leave acquisition running; only the second ends it
  a_sample_len: assert property (
    state_q == SAS_SAMPLE && bclk_fall && !sel_n && fall_cnt_q == 2'h0
    |=> state_q == SAS_SAMPLE && sample_o)
    else $error("sampling ended before second falling edge");
  a_null_bit: assert property (
    s_null_edge |=> serial_data_oe_o && !serial_data_o && !sample_o)
    else $error("null bit not driven low");
  a_msb_order: assert property (
    state_q == SAS_MSB_FIRST && bclk_fall && !sel_n && out_idx_q != '0
    |=> serial_data_o == result_q[out_idx_q])
    else $error("MSB-first bit mismatch");
  a_lsb_order: assert property (
    state_q == SAS_LSB_FIRST && bclk_fall && !sel_n
    && out_idx_q != IW'(RES_BITS - 1) |=> serial_data_o == result_q[out_idx_q])
    else $error("LSB-first bit mismatch");
  a_done_float: assert property (
    state_q == SAS_DONE |-> !serial_data_oe_o)
    else $error("output driven after transfer end");
  a_no_restart: assert property (
    state_q == SAS_DONE && !sel_n |=> state_q == SAS_DONE)
    else $error("conversion restarted without select cycle");
  a_edge_only: assert property (
    $changed(serial_data_o) |-> $past(bclk_fall) || $past(sel_n))
    else $error("output changed off a falling edge");
  a_desel_float: assert property (
    sel_n |=> !serial_data_oe_o && state_q == SAS_IDLE && !sar_busy_q)
    else $error("deselect did not float output");
  a_analog_off: assert property (conv_done |=> !analog_on_o [*2])
    else $error("analog stayed on after completion");
  a_mid_start: assert property (
    conv_start |=> trial_code_o == `SAS_MID_CODE)
    else $error("search did not start at mid-scale");

endmodule

`default_nettype wire

// *** pkg/sas_consts.svh ***
`ifndef SAS_CONSTS_SVH
`define SAS_CONSTS_SVH

// Resolution of the converter result
`define SAS_RES_BITS 12
// First trial code of a search, mid-scale
`define SAS_MID_CODE 12'h800
// Falling bit-clock edges spent sampling before the null bit
`define SAS_SAMPLE_FALLS 2
// Depth of the decided-bit buffer
`define SAS_FIFO_DEPTH 8
// Flip-flops in each pin synchroniser
`define SAS_SYNC_STAGES 3
// Reset level of the synchronised pins: {select_shutdown_n, bit_clock}
`define SAS_PIN_RST 2'h2

`endif

// *** pkg/sas_pkg.sv ***
`include "sas_consts.svh"

package sas_pkg;

  // Transfer sequencer states
  typedef enum logic [2:0] {
    SAS_IDLE,
    SAS_SAMPLE,
    SAS_NULL,
    SAS_MSB_FIRST,
    SAS_LSB_FIRST,
    SAS_DONE
  } sas_state_t;

  typedef logic [`SAS_RES_BITS-1:0] sas_code_t;

endpackage

// *** rtl/sas_pin_sync.sv ***
`timescale 1ns/1ns
`default_nettype none

module sas_pin_sync #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Raw pins
  input wire logic [WIDTH-1:0] pin_i,
  // Filtered level and edge pulses
  output logic [WIDTH-1:0] level_o,
  output logic [WIDTH-1:0] rise_o,
  output logic [WIDTH-1:0] fall_o
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] lvl_d;

  // Three-stage chain; the first stage feeds only the second
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end
    else
    begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts once stages two and three agree
  always_comb
  begin
    lvl_d = level_o;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (s2_q[i] == s3_q[i])
      begin
        lvl_d[i] = s3_q[i];
      end
    end
  end

  // Level and one-cycle edge pulses, all registered
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      level_o <= RST_VAL;
      rise_o <= '0;
      fall_o <= '0;
    end
    else
    begin
      level_o <= lvl_d;
      rise_o <= lvl_d & ~level_o;
      fall_o <= ~lvl_d & level_o;
    end
  end

endmodule

`default_nettype wire

// *** rtl/sas_fifo.sv ***
`timescale 1ns/1ns
`default_nettype none

module sas_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Drop everything held
  input wire logic flush_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  // Pointers carry one extra wrap bit to tell full from empty
  assign in_ready_o = (wr_q[AW] == rd_q[AW])
    || (wr_q[AW-1:0] != rd_q[AW-1:0]);
  assign out_valid_o = (wr_q != rd_q);
  assign out_data_o = mem_q[rd_q[AW-1:0]];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Storage
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
  end

  // Pointers; flush wins over any transfer in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i || flush_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= wr_q + (AW+1)'(1);
      end
      if (pop)
      begin
        rd_q <= rd_q + (AW+1)'(1);
      end
    end
  end

endmodule

`default_nettype wire

// *** verification/sas_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ********
// Host serial controller
// ********
module sas_host_model (
  // Clock
  input wire logic clk_i,
  // Device pins
  output logic select_shutdown_n_o,
  output logic bit_clock_o,
  input wire logic serial_data_i,
  input wire logic serial_data_oe_i
);
  logic [31:0] oe_seen;
  logic [31:0] dat_seen;
  logic line_q;

  // Idle in shutdown with the clock parked low
  initial
  begin
    select_shutdown_n_o = 1'b1;
    bit_clock_o = 1'b0;
    line_q = 1'b0;
  end

  // Select, then run n periods of 2*h clk; select stays low afterwards
  task automatic run(input int n, input int h);
    oe_seen = '0;
    dat_seen = '0;
    @(posedge clk_i);
    select_shutdown_n_o <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      repeat (h) @(posedge clk_i);
      bit_clock_o <= 1'b1;
      // A floating line is not trusted to hold its last level
      line_q = serial_data_oe_i ? serial_data_i : ~line_q;
      oe_seen[i] = serial_data_oe_i;
      dat_seen[i] = line_q;
      repeat (h) @(posedge clk_i);
      bit_clock_o <= 1'b0;
    end
  endtask

  // Deselect ends the transfer, whatever its progress
  task automatic release_sel();
    @(posedge clk_i);
    select_shutdown_n_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

// *** verification/sas_serial_adc_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
// ********
// Serial converter bench
// ********
module sas_serial_adc_bench;
  import sas_pkg::*;
  logic clk, rst_b, cmp_high, sel_n, bclk, sdata, soe;
  logic smp, a_on, d_on, rvalid;
  sas_code_t trial, result, ain, held_q;
  logic [31:0] smp_seen;
  int n_mismatch;
  int checked;
  int nres;

  sas_serial_adc dut (
    .clk_i(clk), .rst_b_i(rst_b),
    .select_shutdown_n_i(sel_n), .bit_clock_i(bclk),
    .serial_data_o(sdata), .serial_data_oe_o(soe),
    .compare_high_i(cmp_high), .trial_code_o(trial),
    .sample_o(smp), .analog_on_o(a_on), .digital_on_o(d_on),
    .result_o(result), .result_valid_o(rvalid)
  );

  sas_host_model host (
    .clk_i(clk), .select_shutdown_n_o(sel_n), .bit_clock_o(bclk),
    .serial_data_i(sdata), .serial_data_oe_i(soe)
  );

  // 250 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Analog side: track while sampling and hold after, so late input moves are ignored
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      held_q <= '0;
      cmp_high <= 1'b0;
    end
    else
    begin
      if (smp)
        held_q <= ain;
      cmp_high <= (held_q >= trial);
    end
  end

  // Sampling flag as seen at each rising bit clock
  always @(posedge bclk)
    smp_seen <= {smp_seen[30:0], smp};

  // Count completed results
  always @(posedge clk)
    if (rvalid === 1'b1)
      nres++;

  task automatic check(input string what, input logic [11:0] seen,
                       input logic [11:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Whole transfer plus idle clocks that must change nothing
  task automatic full_frame(input sas_code_t code);
    int r;
    r = nres;
    ain <= code;
    host.run(30, 40);
    check("null bit", 12'(host.dat_seen[2]), 12'h000);
    for (int i = 2; i < 26; i++)
      check("enable", 12'(host.oe_seen[i]), 12'h001);
    for (int i = 3; i < 15; i++)
      check("msb first", 12'(host.dat_seen[i]), 12'(code[14-i]));
    for (int i = 15; i < 26; i++)
      check("lsb first", 12'(host.dat_seen[i]), 12'(code[i-14]));
    for (int i = 26; i < 30; i++)
      check("after frame", 12'(host.oe_seen[i]), 12'h000);
    check("sample window", 12'(smp_seen[29:27]), 12'h006);
    check("result", result, code);
    check("result count", 12'(nres - r), 12'h001);
    check("analog off", 12'(a_on), 12'h000);
    check("digital on", 12'(d_on), 12'h001);
    host.release_sel();
    repeat (10) @(posedge clk);
    check("idle float", 12'(soe), 12'h000);
    check("shutdown", 12'(d_on), 12'h000);
  endtask

  // Short cycle before the search can finish: two bits seen by the host
  task automatic abort_frame(input sas_code_t code, input sas_code_t prev);
    int r;
    r = nres;
    ain <= code;
    host.run(5, 40);
    for (int i = 3; i < 5; i++)
      check("short cycle", 12'(host.dat_seen[i]), 12'(code[14-i]));
    check("abort enable", 12'(soe), 12'h001);
    host.release_sel();
    repeat (8) @(posedge clk);
    check("abort float", 12'(soe), 12'h000);
    check("kept result", result, prev);
    check("no result", 12'(nres - r), 12'h000);
    check("abort shutdown", 12'(d_on), 12'h000);
  endtask

  // Main sequence
  initial
  begin
    rst_b = 1'b0;
    ain = '0;
    n_mismatch = 0;
    checked = 0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (10) @(posedge clk);
    check("reset float", 12'(soe), 12'h000);
    full_frame(12'h000);
    full_frame(12'hFFF);
    full_frame(12'h800);
    full_frame(12'h7FF);
    full_frame(12'hA5C);
    abort_frame(12'h3C6, 12'hA5C);
    full_frame(12'h555);
    final_report();
  end

  // Watchdog, well beyond seven frames
  initial
  begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    final_report();
  end
endmodule
`default_nettype wire
